// >>> hdl/pbg_defines.vh
/*
 port b gpio with change and external interrupt flags: register map, field positions, reset values.
 assumes avalon-mm word addressing with the register index as the word address.
*/
`ifndef PBG_DEFINES_VH
`define PBG_DEFINES_VH

`define PBG_ADDR_W            8
`define PBG_IDX_DATA          8'h06
`define PBG_IDX_OPTION        8'h81
`define PBG_IDX_DIR           8'h86
`define PBG_IDX_IRQ_CTRL      8'h0B
`define PBG_IDX_ALT_CFG       8'h90
`define PBG_OPT_PULLUP_BIT    7
`define PBG_OPT_EDGE_BIT      6
`define PBG_IRQ_CHANGE_BIT    0
`define PBG_IRQ_EXT_BIT       1
`define PBG_ALT_LVP_BIT       0
`define PBG_OPTION_RST        8'hFF
`define PBG_DIR_RST           8'hFF
`define PBG_LATCH_RST         8'h00
`define PBG_LVP_RST           1'b1
`define PBG_EXT_PIN           0
`define PBG_LVP_PIN           3
`define PBG_CHG_LO            4
`define PBG_CHG_HI            7

`endif

// >>> hdl/pbg_edge_det.v
/*
 edge detector for the external interrupt pin: one-cycle pulse on the selected edge.
 assumes the pin input is synchronous to clk_sys_i.
*/
`timescale 1ns/1ps
module pbg_edge_det (
  input  wire clk_sys_i,
  input  wire resetn_i,
  input  wire pin_i,
  input  wire rising_sel_i,
  output wire edge_o
);
  reg pin_q;
  reg armed_q;

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_q   <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      pin_q   <= pin_i;
      armed_q <= 1'b1;
    end
  end

  // no edge until one real sample is held, so a pin pulled high does not fire after reset
  assign edge_o = armed_q & (rising_sel_i ? (pin_i & ~pin_q) : (~pin_i & pin_q));
endmodule // pbg_edge_det

// >>> hdl/pbg_port.v
/*
 eight-bit bidirectional port with pull-ups, change detection on the upper four pins,
 an edge-selectable external interrupt pin and an avalon-mm register slave.
 assumes pins are synchronous to clk_sys_i; the pad resolves the wire from oe and pull-up.
*/
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "pbg_defines.vh"

// Operation
// - direction 1 makes pin input high-z; 0 drives output latch.
// - option bit 7 cleared enables weak pull-ups on all pins.
// - pull-up off on any pin configured as output.
// - pull-ups disabled after power-on reset.
// - only pins 7..4 configured as inputs take part in change detection.
// - inputs compared with copy from last read; mismatches ORed set change flag.
// - a change event can wake the device from sleep.
// - persisting mismatch keeps setting the change flag.
// - any port data read or write refreshes copy, ending mismatch.
// - pin 0 is external interrupt input; edge chosen by option bit 6.
// - enabled peripheral may override a pin direction to input or output.
// - low-voltage programming on by default removes I/O from pin 3.
// - edge select 1 means rising edge, 0 falling edge.
// - global pull-up bit at 1 disables all pull-ups.
module pbg_port #(
  parameter WIDTH = 8
) (
  input  wire                  clk_sys_i,
  input  wire                  resetn_i,
  input  wire [`PBG_ADDR_W-1:0] avs_address_i,
  input  wire                  avs_read_i,
  input  wire                  avs_write_i,
  input  wire [31:0]           avs_writedata_i,
  input  wire [3:0]            avs_byteenable_i,
  output reg  [31:0]           avs_readdata_o,
  output wire                  avs_waitrequest_o,
  input  wire [WIDTH-1:0]      pin_i,
  output wire [WIDTH-1:0]      pin_o,
  output wire [WIDTH-1:0]      pin_oe_o,
  output wire [WIDTH-1:0]      pullup_en_o,
  input  wire [WIDTH-1:0]      periph_en_i,
  input  wire [WIDTH-1:0]      periph_out_i,
  input  wire [WIDTH-1:0]      periph_oe_i,
  output wire                  port_change_o,
  output wire                  ext_irq_o,
  output wire                  wake_o
);
  reg  [WIDTH-1:0] latch_q;
  reg  [WIDTH-1:0] dir_q;
  reg  [7:0]       option_q;
  reg  [WIDTH-1:0] copy_q;
  reg              port_change_flag_q;
  reg              ext_flag_q;
  reg              lvp_q;
  reg              ack_q;
  wire             acc;
  wire             wr_lane0;
  wire             data_acc;
  wire [WIDTH-1:0] eff_in;
  wire [WIDTH-1:0] mism;
  wire             mismatch;
  wire             ext_edge;
  wire             pullup_disable_n;
  wire             ext_irq_edge_select;
  genvar           g;

  // one wait cycle on every access keeps the read path registered
  assign acc               = (avs_read_i | avs_write_i) & ~ack_q;
  assign avs_waitrequest_o = acc;
  assign wr_lane0          = avs_write_i & ack_q & avs_byteenable_i[0];
  assign data_acc          = ack_q & (avs_read_i | avs_write_i) &
                             (avs_address_i == `PBG_IDX_DATA);

  assign pullup_disable_n    = option_q[`PBG_OPT_PULLUP_BIT];
  assign ext_irq_edge_select = option_q[`PBG_OPT_EDGE_BIT];

  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
      wire lvp_pin = lvp_q & (g == `PBG_LVP_PIN);
      wire is_in   = periph_en_i[g] ? ~periph_oe_i[g] : dir_q[g];
      assign pin_oe_o[g]    = ~is_in & ~lvp_pin;
      assign pin_o[g]       = periph_en_i[g] ? periph_out_i[g] : latch_q[g];
      assign pullup_en_o[g] = ~pullup_disable_n & is_in & ~lvp_pin;
      assign eff_in[g]      = is_in;
      assign mism[g] = (g >= `PBG_CHG_LO && g <= `PBG_CHG_HI) ?
                       (eff_in[g] & (pin_i[g] ^ copy_q[g])) : 1'b0;
    end
  endgenerate

  assign mismatch = |mism;

  pbg_edge_det u_edge (
    .clk_sys_i    (clk_sys_i),
    .resetn_i     (resetn_i),
    .pin_i        (pin_i[`PBG_EXT_PIN]),
    .rising_sel_i (ext_irq_edge_select),
    .edge_o       (ext_edge)
  );

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_q            <= `PBG_LATCH_RST;
      dir_q              <= `PBG_DIR_RST;
      option_q           <= `PBG_OPTION_RST;
      copy_q             <= `PBG_LATCH_RST;
      port_change_flag_q <= 1'b0;
      ext_flag_q         <= 1'b0;
      lvp_q              <= `PBG_LVP_RST;
      ack_q              <= 1'b0;
      avs_readdata_o     <= 32'h0000_0000;
    end else begin
      ack_q <= acc;
      if (data_acc) begin
        copy_q <= pin_i;
      end
      if (acc && avs_read_i) begin
        case (avs_address_i)
          `PBG_IDX_DATA:     avs_readdata_o <= {24'h000000, pin_i};
          `PBG_IDX_OPTION:   avs_readdata_o <= {24'h000000, option_q};
          `PBG_IDX_DIR:      avs_readdata_o <= {24'h000000, dir_q};
          `PBG_IDX_IRQ_CTRL: avs_readdata_o <= {30'h0, ext_flag_q, port_change_flag_q};
          `PBG_IDX_ALT_CFG:  avs_readdata_o <= {31'h0, lvp_q};
          default:           avs_readdata_o <= 32'h0000_0000;
        endcase
      end
      if (wr_lane0) begin
        case (avs_address_i)
          `PBG_IDX_DATA:   latch_q  <= avs_writedata_i[WIDTH-1:0];
          `PBG_IDX_OPTION: option_q <= avs_writedata_i[7:0];
          `PBG_IDX_DIR:    dir_q    <= avs_writedata_i[WIDTH-1:0];
          `PBG_IDX_ALT_CFG: lvp_q   <= avs_writedata_i[`PBG_ALT_LVP_BIT];
          default: begin
          end
        endcase
      end
      // set wins over a software clear in the same cycle
      if (mismatch) begin
        port_change_flag_q <= 1'b1;
      end else if (wr_lane0 && avs_address_i == `PBG_IDX_IRQ_CTRL) begin
        port_change_flag_q <= avs_writedata_i[`PBG_IRQ_CHANGE_BIT];
      end
      if (ext_edge) begin
        ext_flag_q <= 1'b1;
      end else if (wr_lane0 && avs_address_i == `PBG_IDX_IRQ_CTRL) begin
        ext_flag_q <= avs_writedata_i[`PBG_IRQ_EXT_BIT];
      end
    end
  end

  assign port_change_o = port_change_flag_q;
  assign ext_irq_o     = ext_flag_q;
  assign wake_o        = port_change_flag_q | mismatch;
endmodule // pbg_port

// >>> dv/pbg_port_chk.sv
/* port checker: handshake and pin relations; assumes a bind into pbg_port at width 8 */
`timescale 1ns/1ps
module pbg_port_chk (
  input wire logic       clk_sys_i,
  input wire logic       resetn_i,
  input wire logic       avs_read_i,
  input wire logic       avs_write_i,
  input wire logic       avs_waitrequest_o,
  input wire logic       port_change_o,
  input wire logic       ext_irq_o,
  input wire logic       wake_o,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] pullup_en_o,
  input wire logic [7:0] periph_en_i,
  input wire logic [7:0] periph_out_i,
  input wire logic [7:0] periph_oe_i
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  property p_w1; $rose(avs_read_i | avs_write_i) |-> avs_waitrequest_o; endproperty
  a_w1: assert property (p_w1) else $error("no wait state");
  property p_w2; avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_w2: assert property (p_w2) else $error("wait too long");
  property p_pu; (pin_oe_o & pullup_en_o) == 8'h00; endproperty
  a_pu: assert property (p_pu) else $error("pull-up on output");
  property p_rs; $rose(resetn_i) |-> (pin_oe_o | pullup_en_o) == 8'h00; endproperty
  a_rs: assert property (p_rs) else $error("reset pin state");
  property p_oe; ((pin_oe_o ^ periph_oe_i) & periph_en_i & 8'hF7) == 8'h00; endproperty
  a_oe: assert property (p_oe) else $error("override direction");
  property p_po;
    ((pin_o ^ periph_out_i) & periph_en_i & periph_oe_i & 8'hF7) == 8'h00;
  endproperty
  a_po: assert property (p_po) else $error("override value");
  property p_fl; wake_o && !port_change_o |=> port_change_o; endproperty
  a_fl: assert property (p_fl) else $error("flag not set");
  property p_wk; port_change_o |-> wake_o; endproperty
  a_wk: assert property (p_wk) else $error("no wake");
  c_chg: cover property ($rose(port_change_o));
  c_ext: cover property ($rose(ext_irq_o));
  c_per: cover property (periph_en_i != 8'h00);
endmodule // pbg_port_chk

// >>> dv/pbg_pins.sv
/* board side of the pins; assumes the port's own drive wins over the board */
`timescale 1ns/1ps
module pbg_pins (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] pad_out_i,
  input  wire logic [7:0] pad_oe_i,
  input  wire logic [7:0] pad_pu_i,
  input  wire logic [7:0] ext_val_i,
  input  wire logic [7:0] ext_en_i,
  output wire logic [7:0] pad_in_o
);
  logic [7:0] float_q = 8'h5A;
  // a floating line keeps changing so a stale level is never taken as valid
  always @(posedge clk_sys_i) begin
    float_q <= ~float_q;
  end
  assign pad_in_o = pad_oe_i & pad_out_i |
                    ~pad_oe_i & (ext_en_i & ext_val_i | ~ext_en_i & (pad_pu_i | float_q));
endmodule // pbg_pins

// >>> dv/pbg_port_tb_top.sv
/* port bench with random setups and corner cases; assumes pbg_port, pbg_pins, checker */
`timescale 1ns/1ps
`include "pbg_defines.vh"
bind pbg_port pbg_port_chk i_pbg_port_chk (.*);
module pbg_port_tb_top;
  localparam [7:0] IC = `PBG_IDX_IRQ_CTRL;
  localparam [7:0] DT = `PBG_IDX_DATA;
  localparam [7:0] OP = `PBG_IDX_OPTION;
  localparam [7:0] DR = `PBG_IDX_DIR;
  logic        clk_sys_i = 0, resetn_i = 0, rd = 0, wr = 0;
  logic [3:0]  be = 4'hF;
  logic [7:0]  ad = 0, pen = 0, px = 0, pox = 0, ev = 0, ee = 8'hFF, d, l, e, x, r;
  logic [31:0] wd = 0, p;
  wire  [31:0] rq;
  wire  [7:0]  po, oe, pu, pi;
  wire         wt, chg, ext, wk;
  int          num_errors = 0, n_compared = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  pbg_port i_pbg_port (
    .clk_sys_i         (clk_sys_i),
    .resetn_i          (resetn_i),
    .avs_address_i     (ad),
    .avs_read_i        (rd),
    .avs_write_i       (wr),
    .avs_writedata_i   (wd),
    .avs_byteenable_i  (be),
    .avs_readdata_o    (rq),
    .avs_waitrequest_o (wt),
    .pin_i             (pi),
    .pin_o             (po),
    .pin_oe_o          (oe),
    .pullup_en_o       (pu),
    .periph_en_i       (pen),
    .periph_out_i      (px),
    .periph_oe_i       (pox),
    .port_change_o     (chg),
    .ext_irq_o         (ext),
    .wake_o            (wk)
  );
  pbg_pins i_pbg_pins (
    .clk_sys_i (clk_sys_i),
    .pad_out_i (po),
    .pad_oe_i  (oe),
    .pad_pu_i  (pu),
    .ext_val_i (ev),
    .ext_en_i  (ee),
    .pad_in_o  (pi)
  );
  function automatic logic [7:0] pins(logic [7:0] d, l, e, v, u);
    return ~d & l | e & v | u & ~e;
  endfunction
  task automatic chk(logic [7:0] g, w);
    n_compared++;
    if (g !== w) begin
      num_errors++;
      $display("mismatch %0t: %h not %h", $time, g, w);
    end
  endtask
  task automatic acc(logic w, logic [7:0] a, v);
    int n = 0;
    ad <= a;
    wd <= {24'h0, v};
    rd <= !w;
    wr <= w;
    do @(posedge clk_sys_i); while (wt !== 1'b0 && ++n < 20);
    r = rq[7:0];
    rd <= 0;
    wr <= 0;
    @(posedge clk_sys_i);
    if (n == 20) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    p = $urandom(32'hEE08);
    repeat (5) @(posedge clk_sys_i);
    resetn_i <= 1;
    @(posedge clk_sys_i);
    acc(0, OP, 0);
    chk(r, `PBG_OPTION_RST);
    acc(0, DR, 0);
    chk(r, `PBG_DIR_RST);
    chk(pu, 0);
    // a write without lane 0 enabled must leave the register alone
    be <= 4'hE;
    acc(1, DR, 0);
    be <= 4'hF;
    acc(0, DR, 0);
    chk(r, `PBG_DIR_RST);
    acc(0, 8'h33, 0);
    chk(r, 0);
    acc(1, DR, 0);
    chk(oe, 8'hF7);
    acc(1, `PBG_IDX_ALT_CFG, 0);
    chk(oe, 8'hFF);
    $display("reset test done");
    repeat (24) begin
      p = $urandom;
      d = p[7:0];
      l = p[15:8];
      e = p[23:16] & d;
      x = d & {8{~p[31]}};
      ee <= e;
      ev <= p[31:24];
      acc(1, OP, {p[31], 7'h7F});
      acc(1, DR, d);
      acc(1, DT, l);
      acc(0, DT, 0);
      chk(oe, ~d);
      chk(pu, x);
      chk(r & (~d | e | x), pins(d, l, e, p[31:24], x) & (~d | e | x));
      pen <= p[23:16];
      px <= p[15:8];
      pox <= p[7:0] ^ p[15:8];
      @(posedge clk_sys_i);
      @(posedge clk_sys_i);
      chk(oe & p[23:16], (p[7:0] ^ p[15:8]) & p[23:16]);
      pen <= 0;
    end
    $display("random test done");
    ee <= 8'hFF;
    ev <= 0;
    acc(1, DR, 8'hFF);
    acc(1, DT, 0);
    acc(1, IC, 0);
    chk(chg, 0);
    ev <= 8'h0F;
    repeat (3) @(posedge clk_sys_i);
    chk(chg, 0);
    ev <= 8'h2F;
    repeat (3) @(posedge clk_sys_i);
    chk(chg, 1);
    chk(wk, 1);
    acc(1, IC, 0);
    chk(chg, 1);
    acc(0, DT, 0);
    acc(1, IC, 0);
    chk(chg, 0);
    chk(wk, 0);
    for (int k = 0; k < 2; k++) begin
      acc(1, OP, {1'b1, k[0], 6'h3F});
      ev <= {7'h17, !k[0]};
      repeat (3) @(posedge clk_sys_i);
      acc(1, IC, 0);
      chk(ext, 0);
      ev <= {7'h17, k[0]};
      repeat (3) @(posedge clk_sys_i);
      chk(ext, 1);
      chk(chg, 0);
    end
    $display("flag test done");
    finish_test();
  end
endmodule // pbg_port_tb_top
